// >>> eim_meter.sv
// Local design decisions: the APB slave port and the register addresses.
module eim_meter
	import eim_pkg::*;
#(
	parameter int unsigned N_CH = 8
) (
	input  wire logic            i_sys_clk,  // System clock, 20 MHz
	input  wire logic            i_nrst,     // Synchronous reset, active low
	input  wire logic [N_CH-1:0] i_pulse,    // Pulse inputs
	input  wire logic            i_psel,     // APB select
	input  wire logic            i_penable,  // APB enable
	input  wire logic            i_pwrite,   // APB write
	input  wire logic [7:0]      i_paddr,    // APB byte address
	input  wire logic [31:0]     i_pwdata,   // APB write data
	output logic      [31:0]     o_prdata,   // APB read data
	output logic                 o_pready,   // APB ready
	output logic                 o_pslverr,  // APB error, unmapped address
	output logic                 o_new,      // Fresh result pending
	output logic                 o_irq       // Interrupt, level
);
	// Bus and register state
	eim_ctrl_t      ctrl_reg, ctrl_next;
	logic [15:0]    accur_reg, accur_next;
	logic [1:0]     status_reg, status_next;
	logic [1:0]     mask_reg, mask_next;
	logic [31:0]    prdata_reg, prdata_next;
	logic           pready_reg, pready_next;
	logic           pslverr_reg, pslverr_next;
	logic           irq_reg, irq_next;
	logic           new_reg, new_next;
	eim_result_t    res_reg, res_next;

	// Timebase and edge state
	logic [11:0]    tcnt_reg, tcnt_next;
	logic           samp_reg, samp_next;
	logic [31:0]    acc_reg, acc_next;
	logic           armed_reg, armed_next;

	// Divider state
	eim_div_state_t dst_reg, dst_next;
	logic [5:0]     dcnt_reg, dcnt_next;
	logic [47:0]    quo_reg, quo_next;
	logic [32:0]    rem_reg, rem_next;
	logic [31:0]    dvs_reg, dvs_next;

	logic [11:0]    tick_len;
	logic [7:0]     cyc_us;
	logic           tick;
	logic           pin_now;
	logic           rise_hit, fall_hit;
	logic           start_hit, stop_hit;
	logic           publish;
	logic [31:0]    elapsed;
	logic           acc_wr, acc_rd, acc_ok;
	logic [32:0]    rem_sh;
	logic [39:0]    rpm_full;
	logic [63:0]    dividend;
	logic           result_set;

	// Module cycle selection
	always_comb begin
		unique case (ctrl_reg.cycle_sel)
			CYC_SEL_50: begin
				tick_len = TICK_50;
				cyc_us   = CYC_US_50;
			end
			CYC_SEL_200: begin
				tick_len = TICK_200;
				cyc_us   = CYC_US_200;
			end
			default: begin
				tick_len = TICK_100;
				cyc_us   = CYC_US_100;
			end
		endcase
	end

	// Pin is sampled once per module cycle, so every interval is whole ticks
	// Compare with >= so a shorter cycle takes effect without a counter wrap
	assign tick      = (tcnt_reg >= tick_len - 12'h1);
	assign pin_now   = i_pulse[ctrl_reg.channel_select];
	assign rise_hit  = tick && pin_now && !samp_reg;
	assign fall_hit  = tick && !pin_now && samp_reg;
	assign elapsed   = (acc_reg > INTERVAL_MAX - 32'(cyc_us)) ?
		INTERVAL_MAX : acc_reg + 32'(cyc_us);

	// Start and stop edges per edge-enable and frequency mode
	always_comb begin
		start_hit = 1'b0;
		stop_hit  = 1'b0;
		unique case ({ctrl_reg.en_fall, ctrl_reg.en_rise})
			2'b11: begin
				start_hit = rise_hit || fall_hit;
				stop_hit  = rise_hit || fall_hit;
			end
			2'b01: begin
				stop_hit  = rise_hit;
				start_hit = ctrl_reg.en_freq ? rise_hit : fall_hit;
			end
			2'b10: begin
				stop_hit  = fall_hit;
				start_hit = ctrl_reg.en_freq ? fall_hit : rise_hit;
			end
			default: begin
				start_hit = 1'b0;
				stop_hit  = 1'b0;
			end
		endcase
	end

	assign publish = stop_hit && armed_reg;

	always_comb begin
		tcnt_next  = tick ? 12'h0 : tcnt_reg + 12'h1;
		samp_next  = tick ? pin_now : samp_reg;
		acc_next   = acc_reg;
		armed_next = armed_reg;
		if (start_hit) begin
			acc_next   = 32'h0;
			armed_next = 1'b1;
		end else if (stop_hit) begin
			armed_next = 1'b0;
		end else if (tick) begin
			acc_next   = elapsed;
		end
		if (!ctrl_reg.en_fall && !ctrl_reg.en_rise) begin
			armed_next = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			tcnt_reg  <= 12'h0;
			samp_reg  <= 1'b0;
			acc_reg   <= 32'h0;
			armed_reg <= 1'b0;
		end else begin
			tcnt_reg  <= tcnt_next;
			samp_reg  <= samp_next;
			acc_reg   <= acc_next;
			armed_reg <= armed_next;
		end
	end

	// Restoring divider: (accuracy * 1e6 + interval / 2) / interval
	assign dividend = 64'(accur_reg) * 64'(US_SCALE) + 64'(elapsed >> 1);
	assign rem_sh   = {rem_reg[31:0], quo_reg[47]};
	assign rpm_full = 40'(quo_reg[31:0]) * RPM_FACTOR;

	always_comb begin
		dst_next  = dst_reg;
		dcnt_next = dcnt_reg;
		quo_next  = quo_reg;
		rem_next  = rem_reg;
		dvs_next  = dvs_reg;
		unique case (dst_reg)
			DIV_IDLE: begin
				dcnt_next = 6'h0;
			end
			DIV_RUN: begin
				if (rem_sh >= {1'b0, dvs_reg}) begin
					rem_next = rem_sh - {1'b0, dvs_reg};
					quo_next = {quo_reg[46:0], 1'b1};
				end else begin
					rem_next = rem_sh;
					quo_next = {quo_reg[46:0], 1'b0};
				end
				dcnt_next = dcnt_reg + 6'h1;
				if (dcnt_reg == DIV_STEPS - 6'h1) begin
					dst_next = DIV_DONE;
				end
			end
			DIV_DONE: begin
				dst_next = DIV_IDLE;
			end
		endcase
		// A newer edge restarts the division; the old result is dropped
		if (publish && ctrl_reg.en_freq) begin
			dst_next  = DIV_RUN;
			dcnt_next = 6'h0;
			quo_next  = dividend[47:0];
			rem_next  = 33'h0;
			dvs_next  = elapsed;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			dst_reg  <= DIV_IDLE;
			dcnt_reg <= 6'h0;
			quo_reg  <= 48'h0;
			rem_reg  <= 33'h0;
			dvs_reg  <= 32'h0;
		end else begin
			dst_reg  <= dst_next;
			dcnt_reg <= dcnt_next;
			quo_reg  <= quo_next;
			rem_reg  <= rem_next;
			dvs_reg  <= dvs_next;
		end
	end

	// APB access, answered in the access cycle with no wait state
	// Read fetched in setup so data stands beside ready in the access cycle
	assign acc_rd = i_psel && !i_penable && !i_pwrite;
	assign acc_wr = i_psel && i_penable && i_pwrite;
	always_comb begin
		unique case (i_paddr)
			OFS_CTRL, OFS_ACCUR, OFS_INTERVAL, OFS_FREQ, OFS_RPM,
			OFS_STATUS, OFS_MASK, OFS_CYCLE: acc_ok = 1'b1;
			default: acc_ok = 1'b0;
		endcase
	end

	assign result_set = (publish && !ctrl_reg.en_freq) || (dst_reg == DIV_DONE);

	always_comb begin
		ctrl_next    = ctrl_reg;
		accur_next   = accur_reg;
		mask_next    = mask_reg;
		res_next     = res_reg;
		status_next  = status_reg;
		prdata_next  = 32'h0;
		pready_next  = i_psel && !i_penable;
		pslverr_next = i_psel && !i_penable && !acc_ok;
		if (acc_wr && acc_ok) begin
			unique case (i_paddr)
				OFS_CTRL: begin
					ctrl_next.en_fall        = i_pwdata[CTL_FALL_BIT];
					ctrl_next.en_rise        = i_pwdata[CTL_RISE_BIT];
					ctrl_next.en_freq        = i_pwdata[CTL_FREQ_BIT];
					ctrl_next.channel_select = i_pwdata[CTL_CH_LSB +: 3];
					ctrl_next.cycle_sel      = i_pwdata[CTL_CYC_LSB +: 2];
				end
				OFS_ACCUR:  accur_next  = i_pwdata[15:0];
				OFS_STATUS: status_next = status_reg & ~i_pwdata[1:0];
				OFS_MASK:   mask_next   = i_pwdata[1:0];
				default: ;
			endcase
		end
		if (publish) begin
			res_next.interval = elapsed;
			if (!ctrl_reg.en_freq) begin
				res_next.freq = 32'h0;
				res_next.rotational_speed  = 32'h0;
			end
		end
		if (dst_reg == DIV_DONE) begin
			res_next.freq = quo_reg[31:0];
			res_next.rotational_speed  = (rpm_full[39:32] != 8'h0) ? INTERVAL_MAX : rpm_full[31:0];
		end
		if (!ctrl_reg.en_fall && !ctrl_reg.en_rise) begin
			res_next.interval = 32'h0;
		end
		// Setting wins over a same-cycle write-one clear
		if (result_set) begin
			status_next[ST_NEW] = 1'b1;
			if (status_reg[ST_NEW]) begin
				status_next[ST_LOST] = 1'b1;
			end
		end
		if (acc_rd && acc_ok) begin
			unique case (i_paddr)
				OFS_CTRL: begin
					prdata_next[CTL_FALL_BIT]       = ctrl_reg.en_fall;
					prdata_next[CTL_RISE_BIT]       = ctrl_reg.en_rise;
					prdata_next[CTL_FREQ_BIT]       = ctrl_reg.en_freq;
					prdata_next[CTL_CH_LSB +: 3]    = ctrl_reg.channel_select;
					prdata_next[CTL_CYC_LSB +: 2]   = ctrl_reg.cycle_sel;
				end
				OFS_ACCUR:    prdata_next = 32'(accur_reg);
				OFS_INTERVAL: prdata_next = res_reg.interval;
				OFS_FREQ:     prdata_next = res_reg.freq;
				OFS_RPM:      prdata_next = res_reg.rotational_speed;
				OFS_STATUS:   prdata_next = 32'(status_reg);
				OFS_MASK:     prdata_next = 32'(mask_reg);
				OFS_CYCLE:    prdata_next = 32'(cyc_us);
				default: ;
			endcase
		end
		new_next = status_next[ST_NEW];
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			ctrl_reg    <= CTRL_RST;
			accur_reg   <= ACCUR_RST;
			mask_reg    <= 2'h0;
			status_reg  <= 2'h0;
			res_reg     <= '0;
			prdata_reg  <= 32'h0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			new_reg     <= 1'b0;
			irq_reg     <= 1'b0;
		end else begin
			ctrl_reg    <= ctrl_next;
			accur_reg   <= accur_next;
			mask_reg    <= mask_next;
			status_reg  <= status_next;
			res_reg     <= res_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			new_reg     <= new_next;
			irq_reg     <= irq_next;
		end
	end

	assign o_prdata  = prdata_reg;
	assign o_pready  = pready_reg;
	assign o_pslverr = pslverr_reg;
	assign o_new     = new_reg;
	assign o_irq     = irq_reg;
endmodule : eim_meter

// >>> eim_pkg.sv
package eim_pkg;
	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam int unsigned US_PER_S     = 1_000_000;
	// Module cycle choices in microseconds
	localparam logic [7:0]  CYC_US_50    = 8'h32;
	localparam logic [7:0]  CYC_US_100   = 8'h64;
	localparam logic [7:0]  CYC_US_200   = 8'hc8;
	localparam int unsigned CLK_PER_US   = CLK_HZ / US_PER_S;
	localparam logic [11:0] TICK_50      = 12'(50 * CLK_PER_US);
	localparam logic [11:0] TICK_100     = 12'(100 * CLK_PER_US);
	localparam logic [11:0] TICK_200     = 12'(200 * CLK_PER_US);
	localparam logic [1:0]  CYC_SEL_50   = 2'h0;
	localparam logic [1:0]  CYC_SEL_100  = 2'h1;
	localparam logic [1:0]  CYC_SEL_200  = 2'h2;
	localparam logic [47:0] US_SCALE     = 48'(US_PER_S);
	localparam logic [39:0] RPM_FACTOR   = 40'h3c;
	localparam logic [5:0]  DIV_STEPS    = 6'h30;
	localparam logic [31:0] INTERVAL_MAX = 32'hffffffff;

	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_ACCUR    = 8'h04;
	localparam logic [7:0]  OFS_INTERVAL = 8'h08;
	localparam logic [7:0]  OFS_FREQ     = 8'h0c;
	localparam logic [7:0]  OFS_RPM      = 8'h10;
	localparam logic [7:0]  OFS_STATUS   = 8'h14;
	localparam logic [7:0]  OFS_MASK     = 8'h18;
	localparam logic [7:0]  OFS_CYCLE    = 8'h1c;

	// Control field positions
	localparam int unsigned CTL_FALL_BIT = 0;
	localparam int unsigned CTL_RISE_BIT = 1;
	localparam int unsigned CTL_FREQ_BIT = 2;
	localparam int unsigned CTL_CH_LSB   = 4;
	localparam int unsigned CTL_CYC_LSB  = 8;

	localparam logic [15:0] ACCUR_RST    = 16'h03e8;
	localparam int unsigned ST_NEW       = 0;
	localparam int unsigned ST_LOST      = 1;

	typedef struct packed {
		logic       en_fall;
		logic       en_rise;
		logic       en_freq;
		logic [2:0] channel_select;
		logic [1:0] cycle_sel;
	} eim_ctrl_t;

	localparam eim_ctrl_t CTRL_RST = '{en_fall: 1'b0, en_rise: 1'b0, en_freq: 1'b0,
		channel_select: 3'h0, cycle_sel: CYC_SEL_100};

	typedef struct packed {
		logic [31:0] interval;
		logic [31:0] freq;
		logic [31:0] rotational_speed;
	} eim_result_t;

	typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_DONE} eim_div_state_t;
endpackage : eim_pkg

// >>> eim_props.sv
module eim_props
	import eim_pkg::*;
#(
	parameter int unsigned N_CH = 8
) (
	input wire logic            i_sys_clk,  // Clock
	input wire logic            i_nrst,     // Reset
	input wire logic [N_CH-1:0] i_pulse,    // Pulses
	input wire logic            i_psel,     // Select
	input wire logic            i_penable,  // Enable
	input wire logic            i_pwrite,   // Write
	input wire logic [7:0]      i_paddr,    // Address
	input wire logic [31:0]     i_pwdata,   // Write data
	input wire logic [31:0]     o_prdata,   // Read data
	input wire logic            o_pready,   // Ready
	input wire logic            o_pslverr,  // Error
	input wire logic            o_new,      // Fresh
	input wire logic            o_irq       // Interrupt
);
	logic rd;
	logic clr;
	assign rd = o_pready && !i_pwrite;
	assign clr = i_psel && i_penable && i_pwrite && i_paddr == OFS_STATUS && i_pwdata[ST_NEW];
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);
	property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready late");
	property p_one; o_pready |=> !o_pready; endproperty
	a_one: assert property (p_one) else $error("ready held");
	property p_idle; !o_pready |-> o_prdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("data off");
	property p_err;
		o_pready && i_paddr[1:0] == 2'h0 |-> o_pslverr == (i_paddr > OFS_CYCLE);
	endproperty
	a_err: assert property (p_err) else $error("bad error");
	// Flag may only drop after software clears it
	property p_clr; $fell(o_new) |-> $past(clr) || $past(clr, 2); endproperty
	a_clr: assert property (p_clr) else $error("flag lost");
	property p_cyc;
		rd && i_paddr == OFS_CYCLE |-> o_prdata inside {32'h32, 32'h64, 32'hc8};
	endproperty
	a_cyc: assert property (p_cyc) else $error("bad cycle");
	property p_tick; rd && i_paddr == OFS_INTERVAL |-> o_prdata % 32'h32 == 32'h0; endproperty
	a_tick: assert property (p_tick) else $error("off tick");
	property p_rpm; rd && i_paddr == OFS_RPM |-> o_prdata % 32'h3c == 32'h0 || &o_prdata; endproperty
	a_rpm: assert property (p_rpm) else $error("bad speed");
endmodule : eim_props

bind eim_meter eim_props #(.N_CH(N_CH)) u_props (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
	.i_pulse(i_pulse), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_new(o_new), .o_irq(o_irq));

// >>> eim_pulse_src.sv
module eim_pulse_src #(
	parameter int unsigned CH = 1
) (
	input  wire logic        i_clk,   // Clock
	input  wire logic        i_run,   // Emit waveform
	input  wire logic [15:0] i_hi,    // High clocks
	input  wire logic [15:0] i_lo,    // Low clocks
	output logic      [7:0]  o_pulse  // Lines
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        lvl_reg;
	logic [15:0] cnt_reg;
	// Idle low; bench keeps the period at 500 us or longer
	always_ff @(posedge i_clk) begin
		if (!i_run) begin
			lvl_reg <= 1'b0;
			cnt_reg <= 16'h0;
		end else if (cnt_reg + 16'h1 >= (lvl_reg ? i_hi : i_lo)) begin
			lvl_reg <= !lvl_reg;
			cnt_reg <= 16'h0;
		end else begin
			cnt_reg <= cnt_reg + 16'h1;
		end
	end
	// Other lines inverse, so a wrong channel gives swapped times
	always_comb begin
		o_pulse     = {8{!lvl_reg}};
		o_pulse[CH] = lvl_reg;
	end
endmodule : eim_pulse_src

// >>> eim_tb.sv
module testbench
	import eim_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_sys_clk = 1'b0;
	logic        i_nrst    = 1'b0;
	logic        i_psel    = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite  = 1'b0;
	logic [7:0]  i_paddr   = 8'h0;
	logic [31:0] i_pwdata  = 32'h0;
	logic [31:0] o_prdata;
	logic        o_pready, o_pslverr, o_new, o_irq;
	logic [7:0]  pulse;
	logic        run  = 1'b0;
	logic [15:0] hi_t = 16'h0;
	logic [15:0] lo_t = 16'h0;
	logic [31:0] rd;
	logic        er;
	int          miscompares = 0;
	int          cmp_count   = 0;
	int          cycles      = 0;
	eim_meter #(.N_CH(8)) dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_pulse(pulse),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .o_new(o_new), .o_irq(o_irq));
	eim_pulse_src #(.CH(1)) u_src (.i_clk(i_sys_clk), .i_run(run), .i_hi(hi_t),
		.i_lo(lo_t), .o_pulse(pulse));
	always #25 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 95000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		i_psel   <= 1'b1;
		i_pwrite <= w;
		i_paddr  <= a;
		i_pwdata <= d;
		@(posedge i_sys_clk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		chk({31'h0, o_pready}, 32'h1);
		rd = o_prdata;
		er = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	// Lets a just-cleared flag fall before looking
	task automatic wnew();
		int n;
		n = 0;
		repeat (3) @(posedge i_sys_clk);
		while (o_new !== 1'b1 && n < 30000) begin
			@(posedge i_sys_clk);
			n++;
		end
		chk({31'h0, o_new}, 32'h1);
	endtask : wnew
	task automatic s_regs();
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h100);
		apb(1'b0, OFS_ACCUR, 32'h0);
		chk(rd, 32'h3e8);
		for (int s = 0; s < 3; s++) begin
			apb(1'b1, OFS_CTRL, 32'(s) << 8);
			apb(1'b0, OFS_CYCLE, 32'h0);
			chk(rd, 32'h32 << s);
		end
		apb(1'b1, OFS_CYCLE, 32'h0);
		apb(1'b0, OFS_CYCLE, 32'h0);
		chk(rd, 32'hc8);
		apb(1'b0, 8'h20, 32'h0);
		chk({rd[30:0], er}, 32'h1);
	endtask : s_regs
	task automatic s_modes();
		logic [2:0]  m [5] = '{3'h6, 3'h2, 3'h5, 3'h1, 3'h7};
		logic [31:0] e [5] = '{32'h1f4, 32'h12c, 32'h1f4, 32'hc8, 32'hfa};
		logic [31:0] f;
		apb(1'b1, OFS_ACCUR, 32'h3e8);
		run <= 1'b1;
		// Waveform runs on; mode order chosen so each next edge is useful
		for (int i = 0; i < 5; i++) begin
			hi_t <= (i == 4) ? 16'h1388 : 16'h0fa0;
			lo_t <= (i == 4) ? 16'h1388 : 16'h1770;
			// Disarm so no start edge of the old mode carries over
			apb(1'b1, OFS_CTRL, 32'h0);
			apb(1'b1, OFS_CTRL, {25'h0, 3'h1, 1'b0, m[i]});
			apb(1'b1, OFS_STATUS, 32'h3);
			wnew();
			apb(1'b0, OFS_STATUS, 32'h0);
			chk(rd, 32'h1);
			apb(1'b0, OFS_INTERVAL, 32'h0);
			chk(rd, e[i]);
			f = m[i][2] ? (32'h3b9aca00 + e[i] / 32'h2) / e[i] : 32'h0;
			apb(1'b0, OFS_FREQ, 32'h0);
			chk(rd, f);
			apb(1'b0, OFS_RPM, 32'h0);
			chk(rd, f * 32'h3c);
		end
	endtask : s_modes
	task automatic s_off();
		apb(1'b1, OFS_CTRL, 32'h14);
		apb(1'b1, OFS_STATUS, 32'h3);
		repeat (11000) @(posedge i_sys_clk);
		chk({31'h0, o_new}, 32'h0);
		apb(1'b0, OFS_INTERVAL, 32'h0);
		chk(rd, 32'h0);
	endtask : s_off
	task automatic s_lost();
		apb(1'b1, OFS_MASK, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h13);
		apb(1'b1, OFS_STATUS, 32'h3);
		wnew();
		repeat (5200) @(posedge i_sys_clk);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h3);
		chk({31'h0, o_irq}, 32'h0);
		apb(1'b1, OFS_MASK, 32'h1);
		repeat (2) @(posedge i_sys_clk);
		chk({31'h0, o_irq}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h1);
		repeat (3) @(posedge i_sys_clk);
		chk({30'h0, o_irq, o_new}, 32'h0);
		apb(1'b0, OFS_INTERVAL, 32'h0);
		chk(rd, 32'hfa);
	endtask : s_lost
	task automatic tally_and_finish();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (12) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		s_regs();
		s_modes();
		s_off();
		s_lost();
		tally_and_finish();
	end
endmodule : testbench
